// File: design/fdsr_defines.vh
`ifndef FDSR_DEFINES_VH
`define FDSR_DEFINES_VH
`define FDSR_WORD_W 16
`define FDSR_CH_N 8
`define FDSR_CNT_W 6
`define FDSR_FIRST_LEN 6'd16
`define FDSR_NEXT_LEN 6'd8
`define FDSR_CMD_STBY 2'b00
`define FDSR_CMD_INPUT 2'b01
`define FDSR_CMD_ON 2'b10
`define FDSR_CMD_OFF 2'b11
`define FDSR_CMD_RESET 16'hffff
`endif

// File: design/fdsr_sync.v
`timescale 1ns/1ps
`default_nettype none
module fdsr_sync #(
	parameter W = 1
) (
	input wire clk, // system clock
	input wire rst_n, // async reset, active low
	input wire [W-1:0] d, // asynchronous inputs
	output reg [W-1:0] q // synchronised copies
);
	reg [W-1:0] meta_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// File: design/fdsr_channel.v
`timescale 1ns/1ps
`default_nettype none
`include "fdsr_defines.vh"
module fdsr_channel (
	input wire clk, // system clock
	input wire rst_n, // async reset, active low
	input wire [1:0] cmd, // channel command from last good frame
	input wire par_in, // synchronised parallel input
	input wire clr, // one-cycle pulse: command 00 taken
	input wire open_det, // synchronised open-load/short-to-ground comparator
	input wire over_load, // synchronised overcurrent comparator
	input wire over_temp, // synchronised overtemperature sense
	output reg drv_on_q, // driver gate
	output reg open_flag_q, // latched open-load flag
	output reg ovl_flag_q // latched overload/overtemp flag
);
	reg want_on;
	reg diag_en;
	always @* begin
		case (cmd)
			`FDSR_CMD_STBY: begin
				want_on = 1'b0;
				diag_en = 1'b0;
			end
			`FDSR_CMD_INPUT: begin
				want_on = par_in;
				diag_en = 1'b1;
			end
			`FDSR_CMD_ON: begin
				want_on = 1'b1;
				diag_en = 1'b0;
			end
			default: begin
				want_on = 1'b0;
				diag_en = 1'b1;
			end
		endcase
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drv_on_q <= 1'b0;
			open_flag_q <= 1'b0;
			ovl_flag_q <= 1'b0;
		end else begin
			// open load does not gate the driver
			drv_on_q <= want_on & ~ovl_flag_q & ~(drv_on_q & (over_load | over_temp));
			// set wins over clear
			if (!drv_on_q && diag_en && open_det)
				open_flag_q <= 1'b1;
			else if (clr)
				open_flag_q <= 1'b0;
			if ((drv_on_q && over_load) || over_temp)
				ovl_flag_q <= 1'b1;
			else if (clr)
				ovl_flag_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: design/fdsr_top.v
`timescale 1ns/1ps
`default_nettype none
`include "fdsr_defines.vh"
module fdsr_top #(
	parameter CH = `FDSR_CH_N
) (
	input wire clk, // system clock 100 MHz
	input wire rst_n, // async reset, active low
	input wire chip_select_n, // spi select, active low
	input wire sclk, // spi clock from host
	input wire sdi, // serial in
	output reg sdo_q, // serial out data
	output reg sdo_oe_n_q, // serial out enable, low while driving
	input wire [CH-1:0] par_in, // parallel inputs
	input wire [CH-1:0] open_det, // open-load/short-to-ground comparators
	input wire [CH-1:0] over_load, // overcurrent comparators
	input wire [CH-1:0] over_temp, // overtemperature sense
	input wire mode_exit, // level: limp home / uvlo / low-iq-to-off exit
	output reg [CH-1:0] drv_on_q // driver gates
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	wire [3:0] spi_s;
	wire [4*CH:0] ana_s;
	fdsr_sync #(.W(4)) u_spi_sync (
		.clk(clk),
		.rst_n(rst_n),
		// select goes in inverted so the synchroniser's zero reset means idle
		.d({~chip_select_n, sclk, sdi, 1'b0}),
		.q(spi_s)
	);
	fdsr_sync #(.W(4*CH+1)) u_ana_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({mode_exit, par_in, open_det, over_load, over_temp}),
		.q(ana_s)
	);
	wire cs_n = ~spi_s[3];
	wire sck = spi_s[2];
	wire si = spi_s[1];
	wire exit_s = ana_s[4*CH];
	wire [CH-1:0] par_s = ana_s[4*CH-1:3*CH];
	wire [CH-1:0] open_s = ana_s[3*CH-1:2*CH];
	wire [CH-1:0] ovl_s = ana_s[2*CH-1:CH];
	wire [CH-1:0] ot_s = ana_s[CH-1:0];

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	reg cs_n_q, sck_q, exit_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_n_q <= 1'b1;
			sck_q <= 1'b0;
			exit_q <= 1'b0;
		end else begin
			cs_n_q <= cs_n;
			sck_q <= sck;
			exit_q <= exit_s;
		end
	end
	wire cs_fall = cs_n_q & ~cs_n;
	wire cs_rise = ~cs_n_q & cs_n;
	wire sck_rise = ~sck_q & sck;
	wire sck_fall = sck_q & ~sck;
	// a mode exit is the falling edge of the mode level
	wire exit_ev = exit_q & ~exit_s;

	// ----------------------------------------
	// frame shifter
	// ----------------------------------------
	wire [CH-1:0] open_f, ovl_f;
	reg [`FDSR_WORD_W-1:0] rx_q, tx_q;
	reg [`FDSR_CNT_W-1:0] cnt_q;
	reg [2*CH-1:0] cmd_q;
	reg ter_q;
	reg [CH-1:0] clr_q;
	reg [`FDSR_WORD_W-1:0] diag_w;
	integer i;
	integer j;
	// frame good: 16 bits then whole 8-bit groups
	function frame_ok;
		input [`FDSR_CNT_W-1:0] n;
		begin
			frame_ok = (n >= `FDSR_FIRST_LEN) && (n[2:0] == 3'd0);
		end
	endfunction
	always @* begin
		diag_w = {`FDSR_WORD_W{1'b0}};
		for (i = 0; i < CH; i = i + 1) begin
			diag_w[2*i+1] = open_f[i];
			diag_w[2*i] = ovl_f[i];
		end
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_q <= {`FDSR_WORD_W{1'b0}};
			tx_q <= {`FDSR_WORD_W{1'b0}};
			cnt_q <= {`FDSR_CNT_W{1'b0}};
			cmd_q <= `FDSR_CMD_RESET;
			ter_q <= 1'b0;
			clr_q <= {CH{1'b0}};
			sdo_q <= 1'b0;
			sdo_oe_n_q <= 1'b1;
		end else begin
			clr_q <= {CH{1'b0}};
			if (cs_fall) begin
				// snapshot so the word is stable for the whole frame
				tx_q <= diag_w;
				cnt_q <= {`FDSR_CNT_W{1'b0}};
				sdo_q <= ter_q;
				sdo_oe_n_q <= 1'b0;
			end else if (!cs_n) begin
				if (sck_rise) begin
					rx_q <= {rx_q[`FDSR_WORD_W-2:0], si};
					// saturate so long frames cannot wrap into a good length
					if (cnt_q != {`FDSR_CNT_W{1'b1}})
						cnt_q <= cnt_q + 1'b1;
				end
				if (sck_fall) begin
					// after ter the word follows msb first, then daisy data
					sdo_q <= tx_q[`FDSR_WORD_W-1];
					// newest bit in feeds the tail, so the first bit in leaves after 16
					tx_q <= {tx_q[`FDSR_WORD_W-2:0], rx_q[0]};
				end
			end
			if (cs_rise) begin
				sdo_oe_n_q <= 1'b1;
				if (frame_ok(cnt_q)) begin
					cmd_q <= rx_q;
					for (j = 0; j < CH; j = j + 1)
						clr_q[j] <= (rx_q[2*j+:2] == `FDSR_CMD_STBY);
				end
			end
			// set wins over clear
			if (exit_ev || (cs_rise && !frame_ok(cnt_q)))
				ter_q <= 1'b1;
			else if (cs_rise)
				ter_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// channels
	// ----------------------------------------
	wire [CH-1:0] drv_w;
	genvar g;
	generate
		for (g = 0; g < CH; g = g + 1) begin : g_ch
			fdsr_channel u_ch (
				.clk(clk),
				.rst_n(rst_n),
				.cmd(cmd_q[2*g+:2]),
				.par_in(par_s[g]),
				.clr(clr_q[g]),
				.open_det(open_s[g]),
				.over_load(ovl_s[g]),
				.over_temp(ot_s[g]),
				.drv_on_q(drv_w[g]),
				.open_flag_q(open_f[g]),
				.ovl_flag_q(ovl_f[g])
			);
		end
	endgenerate
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			drv_on_q <= {CH{1'b0}};
		else
			drv_on_q <= drv_w & ~ovl_f;
	end
endmodule
`default_nettype wire

// File: test/fdsr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fdsr_checker #(parameter CH = 8) (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic chip_select_n, // select
	input wire logic sclk, // link
	input wire logic sdo_q, // out
	input wire logic sdo_oe_n_q, // enable
	input wire logic [CH-1:0] par_in, // inputs
	input wire logic [CH-1:0] over_load, // faults
	input wire logic [CH-1:0] over_temp, // faults
	input wire logic [CH-1:0] drv_on_q // gates
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_rst_idle: assert property ($rose(rst_n) |-> sdo_oe_n_q && drv_on_q == '0)
		else $error("not idle");
	a_oe_idle: assert property (chip_select_n [*7] |-> sdo_oe_n_q)
		else $error("oe idle");
	a_oe_on: assert property ($fell(chip_select_n) |-> ##[2:6] !sdo_oe_n_q)
		else $error("oe on");
	a_oe_off: assert property ($rose(chip_select_n) |-> ##[2:6] sdo_oe_n_q)
		else $error("oe off");
	a_sdo_hold: assert property ((!chip_select_n && $stable(sclk)) [*7] |-> $stable(sdo_q))
		else $error("sdo moved");
	a_ovl_off: assert property (
		(over_load & drv_on_q) != '0 |-> ##[1:6] (over_load & drv_on_q) == '0)
		else $error("overload on");
	a_ot_off: assert property (over_temp[CH-1] [*8] |-> !drv_on_q[CH-1])
		else $error("overtemp on");
	// gate must survive an open load, so nothing but faults, commands or its parallel input may drop it
	a_ol_noblk: assert property (
		(chip_select_n && over_load == '0 && over_temp == '0 && $stable(par_in)) [*8]
		##0 drv_on_q[2] |=> drv_on_q[2]) else $error("gate dropped");
endmodule
bind fdsr_top fdsr_checker #(.CH(CH)) chk_u (.*);
`default_nettype wire

// File: test/fdsr_host.sv
`timescale 1ns/1ps
`default_nettype none
module fdsr_host (
	input wire logic clk, // clock
	input wire logic sdo_q, // out
	output var logic chip_select_n = 1'b1, // select
	output var logic sclk = 1'b0, // still between frames
	output var logic sdi = 1'b0 // in
);
	task automatic xfer(input int n, input logic [63:0] d, output logic t, output logic [63:0] q);
		q = '0;
		@(posedge clk);
		chip_select_n <= 1'b0;
		sdi <= d[n-1];
		repeat (12) @(posedge clk);
		t = sdo_q;
		for (int i = n - 1; i >= 0; i--) begin
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
			sdi <= (i > 0) ? d[i-1] : ~d[0]; // released line must not keep last bit
			repeat (5) @(posedge clk);
			q = {q[62:0], sdo_q};
		end
		chip_select_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0, rst_n = 1'b0, mode_exit = 1'b0;
	logic [7:0] par_in = 8'h00, open_det = 8'h00, over_load = 8'h00, over_temp = 8'h00;
	wire chip_select_n, sclk, sdi, sdo_q, sdo_oe_n_q;
	wire [7:0] drv_on_q;
	int num_errors = 0, check_count = 0;
	always #5 clk = ~clk;
	fdsr_top dut_u (.*);
	fdsr_host host_u (.*);
	task automatic chk(input string w, input logic [63:0] g, input logic [63:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("%0d errors in %0d checks", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic fr(input int n, input logic [63:0] d, input logic [63:0] e, input logic et);
		logic t;
		logic [63:0] q;
		host_u.xfer(n, d, t, q);
		chk("ter", t, et);
		chk("sdo", q, e);
	endtask
	task automatic t_open;
		open_det[2] <= 1'b1;
		wt(10);
		open_det[2] <= 1'b0;
		fr(16, 16'hffef, 16'h0020, 1'b0);
		chk("gate3", drv_on_q[2], 1'b1);
		fr(16, 16'hffcf, 16'h0020, 1'b0);
		chk("gate3", drv_on_q[2], 1'b0);
		fr(16, 16'hffff, 16'h0000, 1'b0);
	endtask
	task automatic t_fault;
		fr(16, 16'hbffe, 16'h0000, 1'b0);
		chk("gates", drv_on_q, 8'h81);
		{over_temp[7], over_load[0]} <= 2'b11;
		wt(10);
		{over_temp[7], over_load[0]} <= 2'b00;
		fr(16, 16'hbffe, 16'h4001, 1'b0);
		chk("gates", drv_on_q, 8'h00);
		fr(16, 16'h3ffc, 16'h4001, 1'b0);
		fr(16, 16'hbffe, 16'h0000, 1'b0);
		chk("gates", drv_on_q, 8'h81);
	endtask
	task automatic t_frame;
		fr(12, 12'hffe, 12'h000, 1'b0);
		fr(24, 24'hfffff7, 24'h0000ff, 1'b1);
		par_in[1] <= 1'b1;
		wt(8);
		chk("gate2", drv_on_q[1], 1'b1);
		par_in[1] <= 1'b0;
		fr(16, 16'hffff, 16'h0000, 1'b0);
		mode_exit <= 1'b1;
		wt(6);
		mode_exit <= 1'b0;
		wt(6);
		fr(16, 16'hffff, 16'h0000, 1'b1);
	endtask
	initial begin
		wt(10);
		rst_n <= 1'b1;
		wt(4);
		fr(16, 16'hffff, 16'h0000, 1'b0);
		t_open();
		t_fault();
		t_frame();
		end_of_test();
	end
endmodule
`default_nettype wire
